/* File: inc/jtm_pkg.sv */
package jtm_pkg;

	// ****************************************
	// TAP states and link timing
	// ****************************************
	typedef enum logic [3:0] {
		TAP_RESET = 4'h0,
		TAP_IDLE = 4'h1,
		TAP_SEL_DR = 4'h3,
		TAP_CAP_DR = 4'h2,
		TAP_SH_DR = 4'h6,
		TAP_EX1_DR = 4'h7,
		TAP_PAU_DR = 4'h5,
		TAP_EX2_DR = 4'h4,
		TAP_UPD_DR = 4'hC,
		TAP_SEL_IR = 4'hD,
		TAP_CAP_IR = 4'hF,
		TAP_SH_IR = 4'hE,
		TAP_EX1_IR = 4'hA,
		TAP_PAU_IR = 4'hB,
		TAP_EX2_IR = 4'h9,
		TAP_UPD_IR = 4'h8
	} jtm_tap_t;

	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_SEEK = 2'h1,
		PH_SHIFT = 2'h3,
		PH_DONE = 2'h2
	} jtm_phase_t;

	localparam int DIV_W = 4;
	localparam logic [DIV_W-1:0] DIV_RISE = 4'h7;
	localparam logic [DIV_W-1:0] DIV_FALL = 4'hF;
	localparam logic [DIV_W-1:0] TCK_HIGH_FROM = 4'h8;

	// ****************************************
	// Outgoing byte queue
	// ****************************************
	localparam int PTR_W = 2;
	localparam int CNT_W = 3;
	localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 3'h4;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// ****************************************
	// Register map and fields
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_DATA = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_RX = 8'h10;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_IR_BIT = 1;
	localparam int CMD_KIND_LSB = 2;
	localparam int CMD_SOFTWARE_RESET_BIT_BIT = 7;
	localparam int CMD_LEN_LSB = 8;
	localparam int LEN_W = 8;
	localparam logic [1:0] KIND_NORMAL = 2'h0;
	localparam logic [1:0] KIND_IN_ONLY = 2'h1;
	localparam logic [1:0] KIND_RECIRC = 2'h2;
	localparam int CTRL_W = 5;
	localparam int CTRL_DISC_BIT = 0;
	localparam int CTRL_DTMS_BIT = 1;
	localparam int CTRL_DTDO_BIT = 2;
	localparam int CTRL_DTRST_BIT = 3;
	localparam int CTRL_LOOP_BIT = 4;
	localparam int STAT_DTDI_BIT = 4;
	localparam int STAT_EMPTY_BIT = 5;
	localparam int STAT_FULL_BIT = 6;
	localparam int STAT_BUSY_BIT = 7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Far-end registers
	// ****************************************
	localparam int IR_W = 4;
	localparam int DR_W = 32;
	localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;
	localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
	localparam logic [IR_W-1:0] IR_USER = 4'h2;

	// ****************************************
	// Shared next-state function
	// ****************************************
	function automatic jtm_tap_t tap_next(jtm_tap_t s, logic tms);
		case (s)
			TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			default: tap_next = TAP_RESET;
		endcase
	endfunction

	function automatic logic tap_is_shift(jtm_tap_t s);
		tap_is_shift = (s == TAP_SH_DR) || (s == TAP_SH_IR);
	endfunction

endpackage

/* File: inc/jtm_link_if.sv */
`timescale 1ns/10ps
interface jtm_link_if;
	logic tck;
	logic tms;
	logic trst_n;
	logic m_tdo;
	logic t_tdo_o;
	logic t_tdo_oe;
	logic t_tdo;

	// Pull-up while the far end floats its output
	assign t_tdo = t_tdo_oe ? t_tdo_o : 1'b1;

	modport master (
		output tck,
		output tms,
		output trst_n,
		output m_tdo,
		input t_tdo
	);

	modport target (
		input tck,
		input tms,
		input trst_n,
		input m_tdo,
		output t_tdo_o,
		output t_tdo_oe
	);
endinterface

/* File: hw/jtm_target.sv */
`timescale 1ns/10ps
module jtm_target
	import jtm_pkg::*;
#(
	// Arbitrary identification value
	parameter logic [DR_W-1:0] IDCODE_VAL = 32'h0000_0001
) (
	input wire logic aclk,
	input wire logic aresetn,
	jtm_link_if.target link,
	input wire logic [DR_W-1:0] capture_data,
	output logic [DR_W-1:0] update_data,
	output logic [IR_W-1:0] instr,
	output jtm_tap_t tap_state
);

	typedef struct packed {
		logic [3:0][2:0] sy;
		logic [3:0] f;
		jtm_tap_t st;
		logic [IR_W-1:0] ir;
		logic [IR_W-1:0] ir_sh;
		logic [DR_W-1:0] dr_sh;
		logic [DR_W-1:0] upd;
		logic tdo_o;
		logic tdo_oe;
	} jtm_t_st_t;

	localparam int I_TCK = 0;
	localparam int I_TMS = 1;
	localparam int I_TDI = 2;
	localparam int I_TRST = 3;

	jtm_t_st_t s_q;
	jtm_t_st_t s_d;
	logic [3:0] pins;
	logic rise;
	logic fall;

	function automatic jtm_t_st_t t_reset();
		jtm_t_st_t r;
		r = '0;
		r.sy = '1;
		r.f = '1;
		r.st = TAP_RESET;
		r.ir = IR_IDCODE;
		return r;
	endfunction

	assign pins = {link.trst_n, link.m_tdo, link.tms, link.tck};

	always_comb begin
		s_d = s_q;
		rise = 1'b0;
		fall = 1'b0;
		// ****************************************
		// Pin filters
		// ****************************************
		for (int i = 0; i < 4; i++) begin
			s_d.sy[i] = {s_q.sy[i][1:0], pins[i]};
			if (s_q.sy[i][1] == s_q.sy[i][2]) begin
				s_d.f[i] = s_q.sy[i][2];
			end
		end
		rise = !s_q.f[I_TCK] && s_d.f[I_TCK];
		fall = s_q.f[I_TCK] && !s_d.f[I_TCK];
		// ****************************************
		// Rising edge: capture, shift, advance
		// ****************************************
		if (rise) begin
			case (s_q.st)
				TAP_CAP_DR: begin
					if (s_q.ir == IR_IDCODE) begin
						s_d.dr_sh = IDCODE_VAL;
					end else if (s_q.ir == IR_USER) begin
						s_d.dr_sh = capture_data;
					end else begin
						s_d.dr_sh = '0;
					end
				end
				TAP_SH_DR: begin
					if (s_q.ir == IR_IDCODE || s_q.ir == IR_USER) begin
						s_d.dr_sh = {s_q.f[I_TDI], s_q.dr_sh[DR_W-1:1]};
					end else begin
						s_d.dr_sh[0] = s_q.f[I_TDI];
					end
				end
				TAP_CAP_IR: s_d.ir_sh = IR_CAPTURE_VAL;
				TAP_SH_IR: s_d.ir_sh = {s_q.f[I_TDI], s_q.ir_sh[IR_W-1:1]};
				default: s_d.ir_sh = s_q.ir_sh;
			endcase
			s_d.st = tap_next(s_q.st, s_q.f[I_TMS]);
			if (s_d.st == TAP_RESET) begin
				s_d.ir = IR_IDCODE;
			end
		end
		// ****************************************
		// Falling edge: drive, float, update
		// ****************************************
		if (fall) begin
			s_d.tdo_oe = tap_is_shift(s_q.st);
			s_d.tdo_o = (s_q.st == TAP_SH_IR) ? s_q.ir_sh[0] : s_q.dr_sh[0];
			if (s_q.st == TAP_UPD_DR && s_q.ir == IR_USER) begin
				s_d.upd = s_q.dr_sh;
			end
			if (s_q.st == TAP_UPD_IR) begin
				s_d.ir = s_q.ir_sh;
			end
		end
		if (!s_q.f[I_TRST]) begin
			s_d.st = TAP_RESET;
			s_d.ir = IR_IDCODE;
			s_d.tdo_oe = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= t_reset();
		end else begin
			s_q <= s_d;
		end
	end

	assign link.t_tdo_o = s_q.tdo_o;
	assign link.t_tdo_oe = s_q.tdo_oe;
	assign update_data = s_q.upd;
	assign instr = s_q.ir;
	assign tap_state = s_q.st;

endmodule

/* File: hw/jtm_master.sv */
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - Leave Shift-IR with TMS high, high, low
// - Track states by TMS at rising TCK
// - Model sixteen states, six stable
// - Reset tracker: power-up, hardware, software bit
// - Target loads data register leaving Capture-DR
// - Target drives TDO in Shift-DR, LSB first
// - Target floats TDO in Exit1-DR
// - Target holds data in Pause-DR
// - Target updates on falling edge in Update
// - Target loads fixed value in Capture-IR
// - Target shifts instruction LSB first
// - Target floats TDO in Exit1-IR
// - Four-byte queue, bytes and bits LSB first
// - Host aligns partial byte to lowest bit
// - Command start empties queue; command first
// - Status bit 6 reports queue full
// - Full queue stalls the host write
// - Input-only scans drive TDO high
// - Recirculate scans echo TDI onto TDO
// - Discrete mode drives TDO from register bit
// - Loopback feeds receiver, holds TMS and TDO high
// - Any reset empties queue, not full
// - Reset: TDO, TMS, TRST high, TCK /16
module jtm_master
	import jtm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	jtm_link_if.master link,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	typedef struct packed {
		logic aw_have;
		logic [ADDR_W-1:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic lane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} jtm_axi_t;

	typedef struct packed {
		jtm_axi_t axi;
		logic [DIV_W-1:0] div;
		logic tck;
		logic tms;
		logic tdo;
		logic trst_n;
		logic int_tms;
		logic int_tdo;
		jtm_tap_t trk;
		jtm_phase_t ph;
		logic ir;
		logic [1:0] kind;
		logic [LEN_W:0] left;
		logic [3:0][7:0] mem;
		logic [PTR_W-1:0] wp;
		logic [PTR_W-1:0] rp;
		logic [CNT_W-1:0] cnt;
		logic [2:0] bidx;
		logic [7:0] rx;
		logic rx_last;
		logic [CTRL_W-1:0] ctrl;
		logic [2:0] tdi_s;
		logic tdi_f;
	} jtm_m_st_t;

	jtm_m_st_t s_q;
	jtm_m_st_t s_d;
	jtm_axi_t axi_keep;
	jtm_tap_t nxt;
	logic hold;
	logic push;
	logic pop;
	logic start;
	logic software_reset_bit;
	logic commit;
	logic full;
	logic disc;
	logic loop;
	logic tms_b;
	logic tdo_b;

	function automatic jtm_m_st_t m_reset();
		jtm_m_st_t r;
		r = '0;
		r.tms = 1'b1;
		r.tdo = 1'b1;
		r.trst_n = 1'b1;
		r.int_tms = 1'b1;
		r.int_tdo = 1'b1;
		r.trk = TAP_RESET;
		r.ph = PH_IDLE;
		r.tdi_s = 3'h7;
		r.tdi_f = 1'b1;
		r.axi.awready = 1'b1;
		r.axi.wready = 1'b1;
		r.axi.arready = 1'b1;
		return r;
	endfunction

	// Steers TMS toward a shift state or back to idle
	function automatic logic tms_goal(jtm_tap_t s, logic ir, logic to_sh);
		if (to_sh) begin
			case (s)
				TAP_RESET, TAP_SEL_IR, TAP_CAP_DR, TAP_CAP_IR: tms_goal = 1'b0;
				TAP_SEL_DR: tms_goal = ir;
				default: tms_goal = 1'b1;
			endcase
		end else begin
			case (s)
				TAP_RESET, TAP_IDLE, TAP_UPD_DR, TAP_UPD_IR: tms_goal = 1'b0;
				default: tms_goal = 1'b1;
			endcase
		end
	endfunction

	always_comb begin
		s_d = s_q;
		hold = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		start = 1'b0;
		software_reset_bit = 1'b0;
		nxt = tap_next(s_q.trk, s_q.int_tms);
		tms_b = 1'b1;
		tdo_b = 1'b1;
		disc = s_q.ctrl[CTRL_DISC_BIT];
		loop = s_q.ctrl[CTRL_LOOP_BIT];
		full = (s_q.cnt == FIFO_FULL_CNT);
		commit = s_q.axi.aw_have && s_q.axi.w_have && !s_q.axi.bvalid;
		// ****************************************
		// TDI pin filter
		// ****************************************
		s_d.tdi_s = {s_q.tdi_s[1:0], link.t_tdo};
		if (s_q.tdi_s[1] == s_q.tdi_s[2]) begin
			s_d.tdi_f = s_q.tdi_s[2];
		end
		// ****************************************
		// Rising TCK slot
		// ****************************************
		if (s_q.div == DIV_RISE) begin
			if (tap_is_shift(s_q.trk) && s_q.ph == PH_SHIFT) begin
				// Filtered target bit settles on this very cycle
				s_d.rx = {loop ? s_q.int_tdo : s_d.tdi_f, s_q.rx[7:1]};
				s_d.rx_last = s_d.tdi_f;
				if (s_q.kind == KIND_NORMAL) begin
					s_d.bidx = s_q.bidx + 3'h1;
					pop = (s_q.bidx == LAST_BIT);
				end
				s_d.left = s_q.left - 9'h001;
				if (s_q.left == 9'h001) begin
					s_d.ph = PH_DONE;
				end
			end
			s_d.trk = nxt;
			if (s_q.ph == PH_SEEK && nxt == (s_q.ir ? TAP_SH_IR : TAP_SH_DR)) begin
				s_d.ph = PH_SHIFT;
			end
			if (s_q.ph == PH_DONE && nxt == TAP_IDLE) begin
				s_d.ph = PH_IDLE;
			end
		end
		// ****************************************
		// Falling TCK slot
		// ****************************************
		if (s_q.div == DIV_FALL) begin
			if (s_q.ph == PH_SHIFT && tap_is_shift(s_q.trk) && !disc &&
				s_q.kind == KIND_NORMAL && s_q.cnt == 3'h0) begin
				hold = 1'b1;
			end else begin
				case (s_q.ph)
					PH_SEEK: tms_b = tms_goal(s_q.trk, s_q.ir, 1'b1);
					PH_SHIFT: tms_b = (s_q.left == 9'h001);
					PH_DONE: tms_b = tms_goal(s_q.trk, s_q.ir, 1'b0);
					default: tms_b = (s_q.trk == TAP_RESET);
				endcase
				if (s_q.ph == PH_SHIFT && tap_is_shift(s_q.trk)) begin
					case (s_q.kind)
						KIND_IN_ONLY: tdo_b = 1'b1;
						KIND_RECIRC: tdo_b = s_q.rx_last;
						default: tdo_b = s_q.mem[s_q.rp][s_q.bidx];
					endcase
				end
				if (disc) begin
					tms_b = s_q.ctrl[CTRL_DTMS_BIT];
					tdo_b = s_q.ctrl[CTRL_DTDO_BIT];
				end
				s_d.int_tms = tms_b;
				s_d.int_tdo = tdo_b;
				s_d.tms = loop ? 1'b1 : tms_b;
				s_d.tdo = loop ? 1'b1 : tdo_b;
				s_d.trst_n = disc ? s_q.ctrl[CTRL_DTRST_BIT] : 1'b1;
			end
		end
		s_d.div = hold ? s_q.div : s_q.div + 4'h1;
		s_d.tck = (s_d.div >= TCK_HIGH_FROM);
		// ****************************************
		// Register bus, write side
		// ****************************************
		if (s_axi_awvalid && s_q.axi.awready) begin
			s_d.axi.aw_have = 1'b1;
			s_d.axi.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.axi.wready) begin
			s_d.axi.w_have = 1'b1;
			s_d.axi.wdata = s_axi_wdata;
			s_d.axi.lane0 = s_axi_wstrb[0];
		end
		if (s_q.axi.bvalid && s_axi_bready) begin
			s_d.axi.bvalid = 1'b0;
		end
		if (commit && !(s_q.axi.awaddr == REG_DATA && full)) begin
			s_d.axi.aw_have = 1'b0;
			s_d.axi.w_have = 1'b0;
			s_d.axi.bvalid = 1'b1;
			s_d.axi.bresp = RESP_OKAY;
			case (s_q.axi.awaddr)
				REG_CMD: begin
					if (s_q.axi.lane0) begin
						software_reset_bit = s_q.axi.wdata[CMD_SOFTWARE_RESET_BIT_BIT];
						start = s_q.axi.wdata[CMD_START_BIT] &&
							s_q.ph == PH_IDLE && !disc;
					end
				end
				REG_CTRL: begin
					if (s_q.axi.lane0) begin
						s_d.ctrl = s_q.axi.wdata[CTRL_W-1:0];
					end
				end
				REG_DATA: push = s_q.axi.lane0;
				REG_STAT, REG_RX: s_d.axi.bresp = RESP_OKAY;
				default: s_d.axi.bresp = RESP_SLVERR;
			endcase
		end
		s_d.axi.awready = !s_d.axi.aw_have;
		s_d.axi.wready = !s_d.axi.w_have;
		// ****************************************
		// Register bus, read side
		// ****************************************
		if (s_q.axi.rvalid && s_axi_rready) begin
			s_d.axi.rvalid = 1'b0;
			s_d.axi.arready = 1'b1;
		end
		if (s_axi_arvalid && s_q.axi.arready) begin
			s_d.axi.arready = 1'b0;
			s_d.axi.rvalid = 1'b1;
			s_d.axi.rresp = RESP_OKAY;
			s_d.axi.rdata = '0;
			case (s_axi_araddr)
				REG_CMD: begin
					s_d.axi.rdata[CMD_LEN_LSB+LEN_W:CMD_LEN_LSB] = s_q.left;
					s_d.axi.rdata[CMD_KIND_LSB+1:CMD_KIND_LSB] = s_q.kind;
					s_d.axi.rdata[CMD_IR_BIT] = s_q.ir;
				end
				REG_CTRL: s_d.axi.rdata[CTRL_W-1:0] = s_q.ctrl;
				REG_STAT: begin
					s_d.axi.rdata[3:0] = s_q.trk;
					s_d.axi.rdata[STAT_DTDI_BIT] = s_q.tdi_f;
					s_d.axi.rdata[STAT_EMPTY_BIT] = (s_q.cnt == 3'h0);
					s_d.axi.rdata[STAT_FULL_BIT] = full;
					s_d.axi.rdata[STAT_BUSY_BIT] = (s_q.ph != PH_IDLE);
				end
				REG_DATA: s_d.axi.rdata = '0;
				REG_RX: s_d.axi.rdata[7:0] = s_q.rx;
				default: s_d.axi.rresp = RESP_SLVERR;
			endcase
		end
		// ****************************************
		// Byte queue and command start
		// ****************************************
		if (push) begin
			s_d.mem[s_q.wp] = s_q.axi.wdata[7:0];
			s_d.wp = s_q.wp + 2'h1;
		end
		if (pop) begin
			s_d.rp = s_q.rp + 2'h1;
		end
		s_d.cnt = s_q.cnt + {2'h0, push} - {2'h0, pop};
		if (start) begin
			s_d.wp = '0;
			s_d.rp = '0;
			s_d.cnt = '0;
			s_d.bidx = '0;
			s_d.ph = PH_SEEK;
			s_d.ir = s_q.axi.wdata[CMD_IR_BIT];
			s_d.kind = s_q.axi.wdata[CMD_KIND_LSB+1:CMD_KIND_LSB];
			s_d.left = {1'b0, s_q.axi.wdata[CMD_LEN_LSB+LEN_W-1:CMD_LEN_LSB]}
				+ 9'h001;
		end
		axi_keep = s_d.axi;
		if (software_reset_bit) begin
			s_d = m_reset();
			s_d.axi = axi_keep;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= m_reset();
		end else begin
			s_q <= s_d;
		end
	end

	assign link.tck = s_q.tck;
	assign link.tms = s_q.tms;
	assign link.trst_n = s_q.trst_n;
	assign link.m_tdo = s_q.tdo;
	assign s_axi_awready = s_q.axi.awready;
	assign s_axi_wready = s_q.axi.wready;
	assign s_axi_bresp = s_q.axi.bresp;
	assign s_axi_bvalid = s_q.axi.bvalid;
	assign s_axi_arready = s_q.axi.arready;
	assign s_axi_rdata = s_q.axi.rdata;
	assign s_axi_rresp = s_q.axi.rresp;
	assign s_axi_rvalid = s_q.axi.rvalid;

endmodule

/* File: verification/jtm_monitor.sv */
`timescale 1ns/10ps
module jtm_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tck,
	input wire logic tms,
	input wire logic trst_n,
	input wire logic m_tdo,
	input wire logic t_tdo_o,
	input wire logic t_tdo_oe,
	input wire logic t_tdo
);
	// ****************************************
	// Link timing checks
	// ****************************************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_tck_low;
		$fell(tck) |-> (!tck) [*8] ##1 tck;
	endproperty
	a_tck_low: assert property (p_tck_low)
		else $error("tck low phase is not eight cycles");

	property p_tck_high;
		$rose(tck) |-> tck [*8];
	endproperty
	a_tck_high: assert property (p_tck_high)
		else $error("tck high phase shorter than eight cycles");

	property p_tms_fall;
		$changed(tms) |-> !tck;
	endproperty
	a_tms_fall: assert property (p_tms_fall)
		else $error("tms changed while tck high");

	property p_tdo_fall;
		$changed(m_tdo) |-> !tck;
	endproperty
	a_tdo_fall: assert property (p_tdo_fall)
		else $error("master tdo changed while tck high");

	property p_trst_fall;
		$changed(trst_n) |-> !tck;
	endproperty
	a_trst_fall: assert property (p_trst_fall)
		else $error("trst_n changed while tck high");

	property p_reset_pins;
		$rose(aresetn) |-> tms && m_tdo && trst_n && !tck;
	endproperty
	a_reset_pins: assert property (p_reset_pins)
		else $error("link pins wrong after reset");

	property p_oe_on;
		$rose(t_tdo_oe) |-> !tck ##1 !tck;
	endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("target enabled its output off the falling edge");

	property p_oe_off;
		$fell(t_tdo_oe) |-> !tck;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("target floated its output off the falling edge");

	property p_tgt_data;
		t_tdo_oe && $changed(t_tdo) |-> !tck;
	endproperty
	a_tgt_data: assert property (p_tgt_data)
		else $error("target data changed while tck high");

	property p_tgt_out;
		$changed(t_tdo_o) |-> !tck;
	endproperty
	a_tgt_out: assert property (p_tgt_out)
		else $error("target output register changed while tck high");
endmodule

/* File: verification/jtag_master_tap_and_out_fifo_tb_top.sv */
`timescale 1ns/10ps
module jtag_master_tap_and_out_fifo_tb_top
	import jtm_pkg::*;
;
	// Arbitrary identification value
	localparam logic [DR_W-1:0] ID = 32'h6B2D94E3;
	logic aclk, aresetn, awv, wv, arv, awr, wr, bv, arr, rv, brd, rrd;
	logic [ADDR_W-1:0] awa, ara;
	logic [31:0] wd, rdat, cap_d, upd, s;
	logic [1:0] br, rr;
	logic [3:0] ins, cir, ws;
	logic [15:0] lf;
	jtm_tap_t tst;
	int fails, compares, k;
	bit col, tlr;
	logic [7:0] bq[$];
	logic tq[$], dq[$];

	jtm_link_if link ();
	jtm_master jtm_master_inst (.aclk(aclk), .aresetn(aresetn), .link(link),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
		.s_axi_rvalid(rv), .s_axi_rready(rrd));
	jtm_target #(.IDCODE_VAL(ID)) jtm_target_inst (.aclk(aclk),
		.aresetn(aresetn), .link(link), .capture_data(cap_d),
		.update_data(upd), .instr(ins), .tap_state(tst));
	jtm_monitor jtm_monitor_inst (.aclk(aclk), .aresetn(aresetn),
		.tck(link.tck), .tms(link.tms), .trst_n(link.trst_n),
		.m_tdo(link.m_tdo), .t_tdo_o(link.t_tdo_o),
		.t_tdo_oe(link.t_tdo_oe), .t_tdo(link.t_tdo));

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	always @(posedge link.tck)
		if (col) begin
			tq.push_back(link.tms);
			dq.push_back(link.m_tdo);
		end

	// ****************************************
	// Bench tasks
	// ****************************************
	function automatic logic [7:0] rb();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf[7:0];
	endfunction

	task automatic chk(input string n, input logic [31:0] v, input logic [31:0] e);
		compares++;
		if (v !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, v);
		end
	endtask

	task automatic summarize();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic tmo();
		fails++;
		summarize();
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		for (int i = 0; i < 20000; i++) begin
			@(posedge aclk);
			if (awv && awr === 1'b1) awv <= 1'b0;
			if (wv && wr === 1'b1) begin
				wv <= 1'b0;
				brd <= 1'b1;
			end
			if (bv === 1'b1 && brd) begin
				brd <= 1'b0;
				chk("bresp", br, e);
				return;
			end
		end
		tmo();
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
		ara <= a;
		arv <= 1'b1;
		for (int i = 0; i < 20000; i++) begin
			@(posedge aclk);
			if (arv && arr === 1'b1) begin
				arv <= 1'b0;
				rrd <= 1'b1;
			end
			if (rv === 1'b1 && rrd) begin
				rrd <= 1'b0;
				d = rdat;
				chk("rresp", rr, e);
				return;
			end
		end
		tmo();
	endtask

	task automatic stat0();
		axr(REG_STAT, s, RESP_OKAY);
		chk("stat0", s[7:0] & 8'hEF, 8'h20);
	endtask

	task automatic scan(input bit ir, input logic [1:0] kd, input int n, input bit lb);
		logic [31:0] cv, u;
		logic sb[$], rc[$], te[$];
		int j, off, cl, m;
		tq = {};
		dq = {};
		col = 1;
		axw(REG_CMD, {16'h0, 8'(n - 1), 4'h0, kd, ir, 1'b1}, RESP_OKAY);
		foreach (bq[i]) begin
			if (i == 4) begin
				axr(REG_STAT, s, RESP_OKAY);
				chk("full", s[STAT_FULL_BIT], 1'b1);
			end
			axw(REG_DATA, {24'h0, bq[i]}, RESP_OKAY);
		end
		for (j = 0; j < 400; j++) begin
			repeat (16) @(posedge aclk);
			axr(REG_STAT, s, RESP_OKAY);
			if (s[STAT_BUSY_BIT] === 1'b0) break;
		end
		if (j == 400) tmo();
		col = 0;
		chk("tracker", s[3:0], 4'(TAP_IDLE));
		repeat (8) @(posedge aclk);
		if (!lb) chk("target", tst, TAP_IDLE);
		for (j = 0; j < n; j++)
			sb.push_back(kd == KIND_NORMAL ? bq[j / 8][j % 8] : 1'b1);
		cl = ir ? IR_W : (cir == IR_IDCODE || cir == IR_USER) ? DR_W : 1;
		cv = ir ? 32'(IR_CAPTURE_VAL) : cir == IR_IDCODE ? ID :
			cir == IR_USER ? cap_d : 32'h0;
		for (j = 0; j < n; j++)
			rc.push_back(j < cl ? cv[j] : sb[j - cl]);
		if (tlr) te.push_back(1'b0);
		te.push_back(1'b1);
		if (ir) te.push_back(1'b1);
		te.push_back(1'b0);
		te.push_back(1'b0);
		off = te.size();
		for (j = 0; j < n; j++) te.push_back(j == n - 1);
		te.push_back(1'b1);
		te.push_back(1'b0);
		while (tq.size() > 0 && tq[0] === tlr) begin
			void'(tq.pop_front());
			void'(dq.pop_front());
		end
		for (j = 0; j < te.size(); j++)
			if (lb) chk("lb_pins", {tq[j], dq[j]}, 2'b11);
			else chk("tms", tq[j], te[j]);
		for (j = 0; j < n && !lb; j++)
			if (kd == KIND_RECIRC) begin
				if (j > 0) chk("recirc", dq[off + j], rc[j - 1]);
			end else
				chk("tdo", dq[off + j], sb[j]);
		u = 0;
		m = n < 8 ? n : 8;
		for (j = 0; j < m; j++) u[7 - j] = lb ? sb[n - 1 - j] : rc[n - 1 - j];
		axr(REG_RX, s, RESP_OKAY);
		chk("rx", s[7:0] >> (8 - m), u[7:0] >> (8 - m));
		if (!lb && !ir && n >= 32 && kd == KIND_NORMAL) begin
			for (j = 0; j < 32; j++) u[j] = sb[n - 32 + j];
			chk("update", upd, u);
		end
		if (!lb && ir) begin
			cir = {sb[n - 1], sb[n - 2], sb[n - 3], sb[n - 4]};
			chk("instr", ins, cir);
		end
		tlr = 0;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		aresetn = 1'b0;
		awv = 1'b0;
		wv = 1'b0;
		arv = 1'b0;
		brd = 1'b0;
		rrd = 1'b0;
		ws = 4'hF;
		awa = 8'h00;
		ara = 8'h00;
		wd = 32'h0;
		cap_d = 32'h0;
		fails = 0;
		compares = 0;
		col = 0;
		tlr = 1;
		cir = IR_IDCODE;
		lf = 16'hB822;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		cap_d <= {rb(), rb(), rb(), rb()};
		@(posedge aclk);
		stat0();
		axr(8'h20, s, RESP_SLVERR);
		axw(8'h24, 32'h0, RESP_SLVERR);
		axw(REG_CTRL, 32'h1A, RESP_OKAY);
		axr(REG_CTRL, s, RESP_OKAY);
		chk("ctrl", s[4:0], 5'h1A);
		ws <= 4'h0;
		axw(REG_CTRL, 32'h0, RESP_OKAY);
		ws <= 4'hF;
		axr(REG_CTRL, s, RESP_OKAY);
		chk("lane0", s[4:0], 5'h1A);
		axw(REG_CTRL, 32'h0, RESP_OKAY);
		bq = {8'h02};
		scan(1, KIND_NORMAL, 4, 0);
		bq = {rb(), rb(), rb(), rb(), rb() & 8'h0F};
		scan(0, KIND_NORMAL, 36, 0);
		bq = {rb(), rb()};
		scan(0, KIND_NORMAL, 8, 0);
		bq = {rb()};
		scan(0, KIND_NORMAL, 8, 0);
		bq = {};
		scan(0, KIND_RECIRC, 32, 0);
		axw(REG_CTRL, 32'h10, RESP_OKAY);
		bq = {rb(), rb()};
		scan(0, KIND_NORMAL, 16, 1);
		for (k = 0; k < 4; k++) begin
			axw(REG_CTRL, 32'h9 | (32'(k) << 1), RESP_OKAY);
			repeat (40) @(posedge aclk);
			chk("disc", {link.tms, link.m_tdo, link.trst_n}, {k[0], k[1], 1'b1});
		end
		axw(REG_CTRL, 32'h1, RESP_OKAY);
		repeat (40) @(posedge aclk);
		chk("trst", {link.trst_n, tst}, {1'b0, TAP_RESET});
		axw(REG_CTRL, 32'h0, RESP_OKAY);
		axw(REG_CMD, 32'h2701, RESP_OKAY);
		repeat (4) axw(REG_DATA, {24'h0, rb()}, RESP_OKAY);
		axr(REG_STAT, s, RESP_OKAY);
		chk("full", s[STAT_FULL_BIT], 1'b1);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		stat0();
		tlr = 1;
		cir = IR_IDCODE;
		scan(0, KIND_IN_ONLY, 32, 0);
		axw(REG_CMD, 32'h0F01, RESP_OKAY);
		axw(REG_DATA, {24'h0, rb()}, RESP_OKAY);
		repeat (600) @(posedge aclk);
		axr(REG_STAT, s, RESP_OKAY);
		chk("stall", {s[7:5], s[3:0]}, {3'b101, 4'(TAP_SH_DR)});
		axw(REG_CMD, 32'h80, RESP_OKAY);
		stat0();
		chk("rst_pins", {link.tms, link.m_tdo, link.trst_n}, 3'b111);
		summarize();
	end
endmodule
